// ===== rtl/src_pkg.sv
/*
  src_pkg: constants for the standby and reset control block.
  assumes a 125 MHz system clock; no registers reachable by software bus.
*/
package src_pkg;
  // clock period in ns and glitch filter time in ns
  localparam int CLK_PERIOD_NS     = 8;
  localparam int RST_FILTER_NS     = 200;
  localparam int RST_FILTER_CYC    = (RST_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_FILTER_W      = 8;
  // standby control register layout and reset value
  localparam int          STBY_W        = 8;
  localparam logic [7:0]  STBY_RESET    = 8'h00;
  localparam int          STBY_HALT_BIT = 0;
  localparam int          STBY_STOP_BIT = 1;
  // reset vector byte addresses, low byte first
  localparam logic [15:0] VEC_LO_ADDR   = 16'h0000;
  localparam logic [15:0] VEC_HI_ADDR   = 16'h0001;

  typedef enum logic [2:0] {
    SRC_RESET,
    SRC_VEC_LO,
    SRC_VEC_HI,
    SRC_WAIT_REL,
    SRC_RUN,
    SRC_HALT,
    SRC_STOP
  } src_state_t;
endpackage

// ===== rtl/src_rst_filter.sv
/*
  src_rst_filter: synchronises the active-low reset pin and filters glitches.
  assumes the pin is asynchronous to clk_sys_in; output changes only after
  the synchronised level has been stable for FILT_CYC cycles.
*/
`timescale 1ns/1ps
module src_rst_filter
  import src_pkg::*;
#(
  parameter int FILT_CYC = RST_FILTER_CYC
) (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic pin_rst_n_in,
  output logic      rst_filt_n_out
);
  logic                    sync1_reg, sync2_reg;
  logic                    filt_reg, filt_next;
  logic [RST_FILTER_W-1:0] cnt_reg, cnt_next;

  // counter clears whenever the levels agree, so short lows never pass
  always_comb begin
    filt_next = filt_reg;
    cnt_next  = '0;
    if (sync2_reg != filt_reg) begin
      if (cnt_reg == RST_FILTER_W'(FILT_CYC - 1)) begin
        filt_next = sync2_reg;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  // two-stage synchroniser, then filter state
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      filt_reg  <= 1'b0;
      cnt_reg   <= '0;
    end else begin
      sync1_reg <= pin_rst_n_in;
      sync2_reg <= sync1_reg;
      filt_reg  <= filt_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign rst_filt_n_out = filt_reg;
endmodule

// ===== rtl/src_standby_ctrl.sv
/*
  src_standby_ctrl: standby (pause / clock-stop) and reset sequencing.
  assumes a cpu core that issues protected and ordinary writes to the
  standby control register as one-cycle strobes, and a memory read port
  answering one cycle after a read strobe.
*/
// Behaviour
// - pause mode halts cpu, clock runs
// - pause exits on irq, nmi or reset
// - stop mode halts cpu and clock
// - stop exits only on nmi or reset
// - modes entered only by register write
// - only protected write changes the register
// - non-complement operand bytes discard the write
// - low reset pin forces reset state
// - reset pin glitches are filtered out
// - reset loads pc from bytes 0,1
// - fetch starts at vector on release
// - external lines high impedance during reset
`timescale 1ns/1ps
module src_standby_ctrl
  import src_pkg::*;
#(
  parameter int FILT_CYC = RST_FILTER_CYC
) (
  input  wire logic              clk_sys_in,
  input  wire logic              sys_rst_in,
  input  wire logic              pin_rst_n_in,
  input  wire logic              nmi_pin_in,
  input  wire logic              irq_pending_in,
  input  wire logic              prot_wr_in,
  input  wire logic [7:0]        prot_op3_in,
  input  wire logic [7:0]        prot_op4_in,
  input  wire logic              store_wr_in,
  input  wire logic [7:0]        store_data_in,
  input  wire logic [7:0]        mem_rdata_in,
  output logic                   mem_rd_out,
  output logic [15:0]            mem_addr_out,
  output logic [15:0]            pc_vector_out,
  output logic                   pc_load_out,
  output logic                   cpu_run_out,
  output logic                   clk_run_out,
  output logic                   ext_oe_out,
  output logic                   wake_irq_out,
  output logic                   wake_nmi_out,
  output logic [STBY_W-1:0]      standby_control_register_out,
  output logic                   prot_reject_out
);
  src_state_t       state_reg, state_next;
  logic [STBY_W-1:0] stby_reg, stby_next;
  logic [15:0]      vec_reg, vec_next;
  logic             pcl_reg, pcl_next;
  logic             rej_reg, rej_next;
  logic             wirq_reg, wirq_next;
  logic             wnmi_reg, wnmi_next;
  logic             rst_filt_n;
  logic             nmi_s1_reg, nmi_s2_reg, nmi_s3_reg;
  logic             nmi_edge;
  logic             prot_ok;

  // pin reset goes through the synchroniser and glitch filter
  src_rst_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_filt (
    .clk_sys_in     (clk_sys_in),
    .sys_rst_in     (sys_rst_in),
    .pin_rst_n_in   (pin_rst_n_in),
    .rst_filt_n_out (rst_filt_n)
  );

  // nmi pin is asynchronous; third stage only feeds the edge detector
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      nmi_s1_reg <= 1'b0;
      nmi_s2_reg <= 1'b0;
      nmi_s3_reg <= 1'b0;
    end else begin
      nmi_s1_reg <= nmi_pin_in;
      nmi_s2_reg <= nmi_s1_reg;
      nmi_s3_reg <= nmi_s2_reg;
    end
  end
  assign nmi_edge = nmi_s2_reg & ~nmi_s3_reg;

  // operand bytes must be bitwise complements
  assign prot_ok = prot_wr_in && (prot_op3_in == ~prot_op4_in);

  // sequencer: reset vector fetch, run, and the two standby modes
  always_comb begin
    state_next = state_reg;
    stby_next  = stby_reg;
    vec_next   = vec_reg;
    pcl_next   = 1'b0;
    rej_next   = 1'b0;
    wirq_next  = 1'b0;
    wnmi_next  = 1'b0;
    case (state_reg)
      SRC_RESET: begin
        state_next = SRC_VEC_LO;
      end
      SRC_VEC_LO: begin
        vec_next[7:0] = mem_rdata_in;
        state_next    = SRC_VEC_HI;
      end
      SRC_VEC_HI: begin
        vec_next[15:8] = mem_rdata_in;
        state_next     = SRC_WAIT_REL;
      end
      SRC_WAIT_REL: begin
        // vector held until the filtered pin rises
        if (rst_filt_n) begin
          pcl_next   = 1'b1;
          state_next = SRC_RUN;
        end
      end
      SRC_RUN: begin
        // ordinary stores are ignored on purpose
        if (prot_ok) begin
          stby_next = prot_op3_in;
          if (prot_op3_in[STBY_STOP_BIT]) begin
            state_next = SRC_STOP;
          end else if (prot_op3_in[STBY_HALT_BIT]) begin
            state_next = SRC_HALT;
          end
        end else if (prot_wr_in) begin
          rej_next = 1'b1;
        end
      end
      SRC_HALT: begin
        if (nmi_edge) begin
          wnmi_next  = 1'b1;
          state_next = SRC_RUN;
        end else if (irq_pending_in) begin
          wirq_next  = 1'b1;
          state_next = SRC_RUN;
        end
      end
      SRC_STOP: begin
        // maskable requests deliberately not looked at here
        if (nmi_edge) begin
          wnmi_next  = 1'b1;
          state_next = SRC_RUN;
        end
      end
      default: begin
        state_next = SRC_RESET;
      end
    endcase
    if (state_next == SRC_RUN && state_reg != SRC_RUN) begin
      stby_next[STBY_HALT_BIT] = 1'b0;
      stby_next[STBY_STOP_BIT] = 1'b0;
    end
    // filtered low pin aborts run and standby; the vector fetch goes on meanwhile
    if (!rst_filt_n) begin
      if (state_reg == SRC_RUN || state_reg == SRC_HALT || state_reg == SRC_STOP) begin
        state_next = SRC_RESET;
      end
      stby_next  = STBY_RESET;
      wirq_next  = 1'b0;
      wnmi_next  = 1'b0;
      rej_next   = 1'b0;
      pcl_next   = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_reg <= SRC_RESET;
      stby_reg  <= STBY_RESET;
      vec_reg   <= 16'h0000;
      pcl_reg   <= 1'b0;
      rej_reg   <= 1'b0;
      wirq_reg  <= 1'b0;
      wnmi_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      stby_reg  <= stby_next;
      vec_reg   <= vec_next;
      pcl_reg   <= pcl_next;
      rej_reg   <= rej_next;
      wirq_reg  <= wirq_next;
      wnmi_reg  <= wnmi_next;
    end
  end

  // vector reads while in reset; data answers one cycle later
  always_comb begin
    mem_rd_out   = 1'b0;
    mem_addr_out = VEC_LO_ADDR;
    if (state_reg == SRC_RESET) begin
      mem_rd_out = 1'b1;
    end else if (state_reg == SRC_VEC_LO) begin
      mem_rd_out   = 1'b1;
      mem_addr_out = VEC_HI_ADDR;
    end
  end

  assign pc_vector_out                = vec_reg;
  assign pc_load_out                  = pcl_reg;
  assign cpu_run_out                  = (state_reg == SRC_RUN);
  assign clk_run_out                  = (state_reg != SRC_STOP);
  assign ext_oe_out                   = (state_reg == SRC_RUN) || (state_reg == SRC_HALT)
                                        || (state_reg == SRC_STOP);
  assign wake_irq_out                 = wirq_reg;
  assign wake_nmi_out                 = wnmi_reg;
  assign standby_control_register_out = stby_reg;
  assign prot_reject_out              = rej_reg;
endmodule

// ===== testbench/src_chk.sv
/* src_chk: port checks for the standby and reset control.
   assumes a bind onto src_standby_ctrl, one clock, sync high reset. */
`timescale 1ns/1ps
module src_chk (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic        pin_rst_n_in,
  input wire logic        irq_pending_in,
  input wire logic        prot_wr_in,
  input wire logic [7:0]  prot_op3_in,
  input wire logic [7:0]  prot_op4_in,
  input wire logic        store_wr_in,
  input wire logic        mem_rd_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic        pc_load_out,
  input wire logic        cpu_run_out,
  input wire logic        clk_run_out,
  input wire logic        ext_oe_out,
  input wire logic        wake_irq_out,
  input wire logic        wake_nmi_out,
  input wire logic [7:0]  standby_control_register_out,
  input wire logic        prot_reject_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic ok_wr;
  // accepted protected write with complemented operands
  assign ok_wr = prot_wr_in && cpu_run_out && (prot_op3_in == ~prot_op4_in);
  a_halt_entry: assert property (ok_wr && prot_op3_in == 8'h01 |=> !cpu_run_out && clk_run_out)
    else $error("halt entry");
  a_stop_entry: assert property (ok_wr && prot_op3_in == 8'h02 |=> !cpu_run_out && !clk_run_out)
    else $error("stop entry");
  a_bad_reject: assert property (prot_wr_in && cpu_run_out && prot_op3_in != ~prot_op4_in
    |=> prot_reject_out && $stable(standby_control_register_out))
    else $error("bad write kept");
  a_store_kept: assert property (store_wr_in && !prot_wr_in && cpu_run_out
    |=> $stable(standby_control_register_out))
    else $error("store changed reg");
  a_stop_no_irq: assert property (!clk_run_out && irq_pending_in |=> !wake_irq_out)
    else $error("irq woke stop");
  a_halt_wake: assert property (standby_control_register_out[1:0] == 2'h1 && !cpu_run_out
    && irq_pending_in |=> cpu_run_out && wake_irq_out)
    else $error("halt not woken");
  a_vec_read: assert property (mem_rd_out |-> mem_addr_out[15:1] == 15'h0 && !ext_oe_out)
    else $error("vector read");
  a_load_pin: assert property (pc_load_out |-> $past(pin_rst_n_in, 2))
    else $error("load with pin low");
  c_irq: cover property (wake_irq_out);
  c_nmi: cover property (wake_nmi_out);
  c_rej: cover property (prot_reject_out);
endmodule

// ===== testbench/src_partner.sv
/* src_partner: reset driver, nmi source and vector memory.
   assumes the bench commands reset and nmi levels. */
`timescale 1ns/1ps
module src_partner #(
  parameter logic [15:0] VEC = 16'h3a5c
) (
  input wire logic        clk_in,
  input wire logic        rst_req_in,
  input wire logic        nmi_req_in,
  input wire logic        mem_rd_in,
  input wire logic [15:0] addr_in,
  output logic            pin_rst_n_out,
  output logic            nmi_out,
  output logic [7:0]      rdata_out
);
  // pin held low while asked, so power-up waits on the bench
  assign pin_rst_n_out = !rst_req_in;
  assign nmi_out = nmi_req_in;
  // low byte at 0, high at 1; bus toggles when not read
  always_ff @(posedge clk_in) begin
    rdata_out <= mem_rd_in ? (addr_in[0] ? VEC[15:8] : VEC[7:0]) : ~rdata_out;
  end
endmodule

// ===== testbench/test_standby_and_reset_control.sv
/* test_standby_and_reset_control: self-checking bench of the block.
   assumes src_partner drives the pins and answers vector reads. */
`timescale 1ns/1ps
module test_standby_and_reset_control;
  logic        clk_sys_in, sys_rst_in, irq_pending_in, prot_wr_in, store_wr_in, rst_req, nmi_req;
  logic [7:0]  prot_op3_in, prot_op4_in, store_data_in, r;
  wire logic   pin_rst_n_in, nmi_pin_in, mem_rd_out, pc_load_out, cpu_run_out, clk_run_out;
  wire logic   ext_oe_out, wake_irq_out, wake_nmi_out, prot_reject_out;
  wire logic [7:0]  mem_rdata_in, standby_control_register_out;
  wire logic [15:0] mem_addr_out, pc_vector_out;
  int          miscompares, total_checks, exp_reg;
  integer      seed = 32'he15f;
  localparam logic [15:0] VEC = 16'h3a5c;

  src_standby_ctrl #(.FILT_CYC(2)) u_src_standby_ctrl (.*);
  src_partner #(.VEC(VEC)) u_src_partner (.clk_in(clk_sys_in), .rst_req_in(rst_req),
    .nmi_req_in(nmi_req), .mem_rd_in(mem_rd_out), .addr_in(mem_addr_out),
    .pin_rst_n_out(pin_rst_n_in), .nmi_out(nmi_pin_in), .rdata_out(mem_rdata_in));

  task step;
    @(posedge clk_sys_in);
    #1;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // one protected write; outputs settled on return
  task pwr(input logic [7:0] a, input logic [7:0] b);
    step;
    prot_wr_in = 1;
    prot_op3_in = a;
    prot_op4_in = b;
    step;
    prot_wr_in = 0;
  endtask
  // bounded wait for the vector load after pin release
  task boot;
    rst_req = 0;
    for (int i = 0; i < 100 && pc_load_out !== 1'b1; i++) step;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    clk_sys_in = 0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // watchdog well beyond the roughly sixty cycles needed
  initial begin
    #100000;
    miscompares++;
    final_report;
  end
  initial begin
    {sys_rst_in, rst_req} = 2'h3;
    {nmi_req, irq_pending_in, prot_wr_in, store_wr_in} = 4'h0;
    {prot_op3_in, prot_op4_in, store_data_in} = 24'h0;
    exp_reg = 0;
    repeat (8) step;
    sys_rst_in = 0;
    repeat (6) step;
    chk("oe", 0, ext_oe_out);
    chk("run", 0, cpu_run_out);
    chk("vec", VEC, pc_vector_out);
    boot;
    chk("vec", VEC, pc_vector_out);
    step;
    chk("run", 1, cpu_run_out);
    store_wr_in = 1;
    store_data_in = $random(seed);
    step;
    store_wr_in = 0;
    step;
    chk("store", exp_reg, standby_control_register_out);
    r = $random(seed);
    pwr(r, ~r ^ 8'h10);
    chk("rej", 1, prot_reject_out);
    chk("reg", exp_reg, standby_control_register_out);
    $display("test writes done");
    pwr(8'h01, 8'hfe);
    exp_reg = 1;
    chk("reg", exp_reg, standby_control_register_out);
    repeat (3) step;
    chk("run", 0, cpu_run_out);
    chk("clk", 1, clk_run_out);
    irq_pending_in = 1;
    step;
    irq_pending_in = 0;
    exp_reg = 0;
    chk("run", 1, cpu_run_out);
    chk("wirq", 1, wake_irq_out);
    chk("reg", exp_reg, standby_control_register_out);
    $display("test halt done");
    pwr(8'h02, 8'hfd);
    chk("clk", 0, clk_run_out);
    irq_pending_in = 1;
    repeat (4) step;
    chk("run", 0, cpu_run_out);
    irq_pending_in = 0;
    nmi_req = 1;
    for (int i = 0; i < 10 && cpu_run_out !== 1'b1; i++) step;
    chk("wnmi", 1, wake_nmi_out);
    nmi_req = 0;
    $display("test stop done");
    rst_req = 1;
    step;
    rst_req = 0;
    repeat (6) step;
    chk("run", 1, cpu_run_out);
    rst_req = 1;
    repeat (8) step;
    chk("run", 0, cpu_run_out);
    chk("oe", 0, ext_oe_out);
    chk("vec", VEC, pc_vector_out);
    boot;
    chk("vec", VEC, pc_vector_out);
    $display("test pin done");
    final_report;
  end
endmodule

bind src_standby_ctrl src_chk u_src_chk (.*);
